// file: hw/rlcc_map.svh
// Offsets, field positions, reset values and rule summary of the link core control register
// What this block does
// - Bit 31 resets core except registers, timing
// - Action bits self-clear; writing 0 does nothing
// - Bit 30 resets only the timing generator
// - Bit 29 resets register block to defaults
// - Bit 28 raises software interrupt when masked in
// - Bit 26 aborts the running RF test
// - Endless transmit abort finishes byte, then CRC
// - Endless receive abort finishes packet or powers off
// - Bit 25 aborts current advertising event
// - Bit 24 aborts current scan window
// - Bit 22 allows single exchange ignoring MD
// - Bit 21 disables sequence number management
// - Bit 20 disables acknowledge scheme
// - Bit 18 bypasses data whitening
// - Bit 17 keeps received CRC, zeroes transmitted
// - Bit 8 enables exchange-table pre-fetch
// - Bits 7:4 hold default receive window
// - Sync accepted when errors within bits 2:0
`ifndef RLCC_MAP_SVH
`define RLCC_MAP_SVH
`define RLCC_CTRL_OFS     32'h0400_0000
`define RLCC_CTRL_RST     32'h0000_0000
`define RLCC_RD_MASK      32'h207F_03F7
`define RLCC_ST_MASK      32'h007F_03F7
`define RLCC_B_CORE_RST   31
`define RLCC_B_TG_RST     30
`define RLCC_B_REG_RST    29
`define RLCC_B_SWINT      28
`define RLCC_B_RFT_ABORT  26
`define RLCC_B_ADV_ABORT  25
`define RLCC_B_SCAN_ABORT 24
`define RLCC_B_MD_DIS     22
`define RLCC_B_SN_DIS     21
`define RLCC_B_NESN_DIS   20
`define RLCC_B_CIPH_DIS   19
`define RLCC_B_WHIT_DIS   18
`define RLCC_B_CRC_DIS    17
`define RLCC_B_HOP_DIS    16
`define RLCC_B_ADV_FILT   9
`define RLCC_B_PREFETCH   8
`define RLCC_F_RXWIN_LSB  4
`define RLCC_F_RXWIN_W    4
`define RLCC_F_SYNC_LSB   0
`define RLCC_F_SYNC_W     3
`define RLCC_RESP_OKAY    2'h0
`define RLCC_RESP_SLVERR  2'h2
`endif

// file: hw/rlcc_pkg.sv
// Types shared by the link core control register block
package rlcc_pkg;
   typedef enum logic [2:0] {
      RLCC_IDLE    = 3'h0,
      RLCC_TX_BYTE = 3'h1,
      RLCC_TX_CRC  = 3'h3,
      RLCC_RX_PKT  = 3'h6,
      RLCC_STOP    = 3'h2
   } rlcc_rft_state_t;
endpackage

// file: hw/rlcc_ctrl.sv
// Link core main control register with AXI4-Lite access and the logic it steers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "rlcc_map.svh"
module rlcc_ctrl #(
   parameter int ADDR_W     = 32,
   parameter int CRC_W      = 24,
   parameter int SYNC_ERR_W = 6
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  s_axi_awvalid,
   output wire logic                  s_axi_awready,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_wvalid,
   output wire logic                  s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output wire logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output wire logic [1:0]            s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output wire logic                  s_axi_arready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   output wire logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output wire logic [31:0]           s_axi_rdata,
   output wire logic [1:0]            s_axi_rresp,
   output wire logic                  core_soft_reset,
   output wire logic                  timing_gen_soft_reset,
   output wire logic                  reg_block_reset,
   input  wire logic                  sw_irq_mask,
   output wire logic                  software_irq_out,
   output wire logic                  advertising_abort,
   output wire logic                  scan_abort,
   input  wire logic                  rftest_tx_endless,
   input  wire logic                  rftest_rx_endless,
   input  wire logic                  tx_byte_done,
   input  wire logic                  tx_crc_done,
   input  wire logic                  rx_access_addr_found,
   input  wire logic                  rx_packet_done,
   output wire logic                  rftest_busy,
   output wire logic                  rftest_stop,
   output wire logic                  rf_power_off,
   output wire logic                  more_data_disable,
   output wire logic                  sequence_number_disable,
   output wire logic                  ack_scheme_disable,
   output wire logic                  cipher_disable,
   output wire logic                  whitening_disable,
   output wire logic                  crc_strip_disable,
   output wire logic                  hop_remap_disable,
   output wire logic                  adv_error_filter_enable,
   output wire logic                  exchange_prefetch_enable,
   output wire logic [3:0]            default_rx_window_us,
   output wire logic [2:0]            sync_word_error_limit,
   input  wire logic                  peer_more_data,
   input  wire logic                  local_more_data,
   output wire logic                  exchange_continue,
   input  wire logic                  hw_sn,
   input  wire logic                  desc_sn,
   input  wire logic                  hw_nesn,
   input  wire logic                  desc_nesn,
   input  wire logic                  rx_hdr_valid,
   input  wire logic                  rx_sn_mismatch,
   input  wire logic                  rx_nesn_mismatch,
   output wire logic                  tx_sn,
   output wire logic                  tx_nesn,
   output wire logic                  sn_error,
   output wire logic                  nesn_error,
   input  wire logic                  link_cipher_enable,
   output wire logic                  payload_encrypt,
   output wire logic                  mic_generate,
   input  wire logic                  tx_data_bit,
   input  wire logic                  whiten_bit,
   output wire logic                  line_bit,
   input  wire logic [CRC_W-1:0]      tx_crc,
   output wire logic [CRC_W-1:0]      tx_crc_out,
   input  wire logic                  rx_pkt_valid,
   input  wire logic                  rx_pkt_error,
   input  wire logic                  rx_on_adv_channel,
   output wire logic                  rx_report,
   input  wire logic                  sync_candidate,
   input  wire logic [SYNC_ERR_W-1:0] sync_bit_errors,
   output wire logic                  sync_found
);

   localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(`RLCC_CTRL_OFS);

   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        aw_got_r, w_got_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
   logic        do_wr, wr_hit, act_wr;
   logic [31:0] static_r, static_nxt, rd_word;
   logic        core_rst_r, tg_rst_r, reg_rst_r, swirq_r, rft_abort_r, adv_abort_r, scan_abort_r;
   rlcc_pkg::rlcc_rft_state_t state_r, state_nxt;
   logic        rft_stop_r, rf_off_r, rft_busy_r;
   logic        exch_r, tx_sn_r, tx_nesn_r, sn_err_r, nesn_err_r, enc_r, mic_r, line_r, report_r, sync_r;
   logic [CRC_W-1:0] crc_out_r;

   // AXI4-Lite write side: address and data taken in either order, answer after both
   always_comb begin
      do_wr = aw_got_r & w_got_r & ~bvalid_r;
      aw_got_nxt = (aw_got_r | (s_axi_awvalid & awready_r)) & ~do_wr;
      w_got_nxt = (w_got_r | (s_axi_wvalid & wready_r)) & ~do_wr;
      bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
      wr_hit = (waddr_r[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]);
      act_wr = do_wr & wr_hit & wstrb_r[3];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RLCC_RESP_OKAY;
         waddr_r   <= '0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
      end else begin
         aw_got_r  <= aw_got_nxt;
         w_got_r   <= w_got_nxt;
         awready_r <= ~aw_got_nxt & ~bvalid_nxt;
         wready_r  <= ~w_got_nxt & ~bvalid_nxt;
         bvalid_r  <= bvalid_nxt;
         if (s_axi_awvalid && awready_r) begin
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            bresp_r <= wr_hit ? `RLCC_RESP_OKAY : `RLCC_RESP_SLVERR;
         end
      end
   end

   // Read side: one read in flight, answer one cycle after the address is taken
   always_comb begin
      rvalid_nxt = (s_axi_arvalid & arready_r) | (rvalid_r & ~s_axi_rready);
      rd_word = static_r & `RLCC_RD_MASK;
      rd_word[`RLCC_B_REG_RST] = reg_rst_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `RLCC_RESP_OKAY;
      end else begin
         arready_r <= ~rvalid_nxt;
         rvalid_r  <= rvalid_nxt;
         if (s_axi_arvalid && arready_r) begin
            if (s_axi_araddr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2]) begin
               rdata_r <= rd_word;
               rresp_r <= `RLCC_RESP_OKAY;
            end else begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= `RLCC_RESP_SLVERR;
            end
         end
      end
   end

   // Static fields; a pending register reset wins over a write landing in the same cycle
   always_comb begin
      static_nxt = static_r;
      if (do_wr && wr_hit) begin
         for (int i = 0; i < 4; i++) begin
            if (wstrb_r[i]) begin
               static_nxt[8*i +: 8] = wdata_r[8*i +: 8];
            end
         end
      end
      static_nxt = static_nxt & `RLCC_ST_MASK;
      if (reg_rst_r) begin
         static_nxt = `RLCC_CTRL_RST;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         static_r <= `RLCC_CTRL_RST;
      end else begin
         static_r <= static_nxt;
      end
   end

   // Action bits live one cycle: a write of 1 fires them, a write of 0 leaves them at 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_rst_r   <= 1'b0;
         tg_rst_r     <= 1'b0;
         reg_rst_r    <= 1'b0;
         swirq_r      <= 1'b0;
         rft_abort_r  <= 1'b0;
         adv_abort_r  <= 1'b0;
         scan_abort_r <= 1'b0;
      end else begin
         core_rst_r   <= act_wr & wdata_r[`RLCC_B_CORE_RST];
         tg_rst_r     <= act_wr & wdata_r[`RLCC_B_TG_RST];
         reg_rst_r    <= act_wr & wdata_r[`RLCC_B_REG_RST];
         swirq_r      <= act_wr & wdata_r[`RLCC_B_SWINT] & sw_irq_mask;
         rft_abort_r  <= act_wr & wdata_r[`RLCC_B_RFT_ABORT];
         adv_abort_r  <= act_wr & wdata_r[`RLCC_B_ADV_ABORT];
         scan_abort_r <= act_wr & wdata_r[`RLCC_B_SCAN_ABORT];
      end
   end

   // RF test abort sequencing; an abort with no endless test running is dropped
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         rlcc_pkg::RLCC_IDLE: begin
            if (rft_abort_r && rftest_tx_endless) begin
               state_nxt = rlcc_pkg::RLCC_TX_BYTE;
            end else if (rft_abort_r && rftest_rx_endless) begin
               state_nxt = rx_access_addr_found ? rlcc_pkg::RLCC_RX_PKT : rlcc_pkg::RLCC_STOP;
            end
         end
         rlcc_pkg::RLCC_TX_BYTE: begin
            if (tx_byte_done) begin
               state_nxt = rlcc_pkg::RLCC_TX_CRC;
            end
         end
         rlcc_pkg::RLCC_TX_CRC: begin
            if (tx_crc_done) begin
               state_nxt = rlcc_pkg::RLCC_STOP;
            end
         end
         rlcc_pkg::RLCC_RX_PKT: begin
            if (rx_packet_done) begin
               state_nxt = rlcc_pkg::RLCC_STOP;
            end
         end
         rlcc_pkg::RLCC_STOP: begin
            state_nxt = rlcc_pkg::RLCC_IDLE;
         end
         default: begin
            state_nxt = rlcc_pkg::RLCC_IDLE;
         end
      endcase
   end

   // Core soft reset clears the packet-side logic but never the register block
   always_ff @(posedge aclk) begin
      if (!aresetn || core_rst_r) begin
         state_r    <= rlcc_pkg::RLCC_IDLE;
         rft_stop_r <= 1'b0;
         rf_off_r   <= 1'b0;
         rft_busy_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         rft_stop_r <= (state_nxt == rlcc_pkg::RLCC_STOP);
         rf_off_r   <= (state_r == rlcc_pkg::RLCC_IDLE) && rft_abort_r && !rftest_tx_endless
                       && rftest_rx_endless && !rx_access_addr_found;
         rft_busy_r <= (state_nxt != rlcc_pkg::RLCC_IDLE);
      end
   end

   // Protocol datapath steered by the disable switches
   always_ff @(posedge aclk) begin
      if (!aresetn || core_rst_r) begin
         exch_r     <= 1'b0;
         tx_sn_r    <= 1'b0;
         tx_nesn_r  <= 1'b0;
         sn_err_r   <= 1'b0;
         nesn_err_r <= 1'b0;
         enc_r      <= 1'b0;
         mic_r      <= 1'b0;
         line_r     <= 1'b0;
         crc_out_r  <= '0;
         report_r   <= 1'b0;
         sync_r     <= 1'b0;
      end else begin
         exch_r     <= ~static_r[`RLCC_B_MD_DIS] & (peer_more_data | local_more_data);
         tx_sn_r    <= static_r[`RLCC_B_SN_DIS] ? desc_sn : hw_sn;
         sn_err_r   <= ~static_r[`RLCC_B_SN_DIS] & rx_hdr_valid & rx_sn_mismatch;
         tx_nesn_r  <= static_r[`RLCC_B_NESN_DIS] ? desc_nesn : hw_nesn;
         nesn_err_r <= ~static_r[`RLCC_B_NESN_DIS] & rx_hdr_valid & rx_nesn_mismatch;
         enc_r      <= link_cipher_enable & ~static_r[`RLCC_B_CIPH_DIS];
         mic_r      <= link_cipher_enable;
         line_r     <= tx_data_bit ^ (whiten_bit & ~static_r[`RLCC_B_WHIT_DIS]);
         crc_out_r  <= static_r[`RLCC_B_CRC_DIS] ? '0 : tx_crc;
         report_r   <= rx_pkt_valid & ~(static_r[`RLCC_B_ADV_FILT] & rx_on_adv_channel
                       & rx_pkt_error);
         sync_r     <= sync_candidate && (sync_bit_errors <= SYNC_ERR_W'(
                       static_r[`RLCC_F_SYNC_LSB +: `RLCC_F_SYNC_W]));
      end
   end

   assign s_axi_awready            = awready_r;
   assign s_axi_wready             = wready_r;
   assign s_axi_bvalid             = bvalid_r;
   assign s_axi_bresp              = bresp_r;
   assign s_axi_arready            = arready_r;
   assign s_axi_rvalid             = rvalid_r;
   assign s_axi_rdata              = rdata_r;
   assign s_axi_rresp              = rresp_r;
   assign core_soft_reset          = core_rst_r;
   assign timing_gen_soft_reset    = tg_rst_r;
   assign reg_block_reset          = reg_rst_r;
   assign software_irq_out         = swirq_r;
   assign advertising_abort        = adv_abort_r;
   assign scan_abort               = scan_abort_r;
   assign rftest_busy              = rft_busy_r;
   assign rftest_stop              = rft_stop_r;
   assign rf_power_off             = rf_off_r;
   assign more_data_disable        = static_r[`RLCC_B_MD_DIS];
   assign sequence_number_disable  = static_r[`RLCC_B_SN_DIS];
   assign ack_scheme_disable       = static_r[`RLCC_B_NESN_DIS];
   assign cipher_disable           = static_r[`RLCC_B_CIPH_DIS];
   assign whitening_disable        = static_r[`RLCC_B_WHIT_DIS];
   assign crc_strip_disable        = static_r[`RLCC_B_CRC_DIS];
   assign hop_remap_disable        = static_r[`RLCC_B_HOP_DIS];
   assign adv_error_filter_enable  = static_r[`RLCC_B_ADV_FILT];
   assign exchange_prefetch_enable = static_r[`RLCC_B_PREFETCH];
   assign default_rx_window_us     = static_r[`RLCC_F_RXWIN_LSB +: `RLCC_F_RXWIN_W];
   assign sync_word_error_limit    = static_r[`RLCC_F_SYNC_LSB +: `RLCC_F_SYNC_W];
   assign exchange_continue        = exch_r;
   assign tx_sn                    = tx_sn_r;
   assign tx_nesn                  = tx_nesn_r;
   assign sn_error                 = sn_err_r;
   assign nesn_error               = nesn_err_r;
   assign payload_encrypt          = enc_r;
   assign mic_generate             = mic_r;
   assign line_bit                 = line_r;
   assign tx_crc_out               = crc_out_r;
   assign rx_report                = report_r;
   assign sync_found               = sync_r;

   // Checks
   sequence s_act_write(int b);
      act_wr && wdata_r[b];
   endsequence

   sequence s_tx_abort;
      state_r == rlcc_pkg::RLCC_IDLE && rft_abort_r && rftest_tx_endless;
   endsequence

   a_core_reset_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      s_act_write(31) |=> core_rst_r ##1 !core_rst_r)
      else $error("core soft reset pulse wrong");
   a_action_selfclear: assert property (@(posedge aclk) disable iff (!aresetn)
      !act_wr |=> !core_rst_r && !tg_rst_r && !reg_rst_r && !rft_abort_r && !adv_abort_r && !scan_abort_r)
      else $error("action bit set without write");
   a_tg_reset_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      act_wr |=> tg_rst_r == $past(wdata_r[30]))
      else $error("timing reset mismatch");
   a_reg_reset_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      reg_rst_r |=> static_r == `RLCC_CTRL_RST)
      else $error("register reset left fields");
   a_swirq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      swirq_r |-> $past(act_wr) && $past(sw_irq_mask) && $past(wdata_r[28]))
      else $error("software irq without masked request");
   a_tx_abort_order: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_r)
      s_tx_abort ##1 !tx_byte_done [*2] |-> state_r == rlcc_pkg::RLCC_TX_BYTE)
      else $error("tx abort left byte early");
   a_rx_abort_off: assert property (@(posedge aclk) disable iff (!aresetn || core_rst_r)
      rf_off_r |-> state_r == rlcc_pkg::RLCC_STOP ##1 rft_stop_r == 1'b0)
      else $error("rx abort power off path wrong");
   a_sn_error_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      sn_err_r |-> !$past(static_r[21]))
      else $error("sn error while disabled");
   a_crc_zeroed: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(static_r[17]) && !$past(core_rst_r) |-> crc_out_r == '0)
      else $error("crc not zeroed");
   a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_r |-> (rdata_r & ~`RLCC_RD_MASK) == 32'h0000_0000)
      else $error("reserved bits read nonzero");

endmodule
`default_nettype wire

// file: testbench/test_radio_link_core_control_reg.sv
// Self-checking bench for the link core main control register
`timescale 1ns/100ps
`default_nettype none
`include "rlcc_map.svh"
module test_radio_link_core_control_reg;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq_mask;
   logic [31:0] awaddr, wdata, araddr, m, rdat;
   logic [3:0]  wstrb;
   logic [1:0]  resp;
   logic [5:0]  pl, f;
   logic [45:0] r;
   int          errors = 0, compares = 0, stops = 0, pwr = 0;
   wire logic   aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, busy, rft_stop, pwroff;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [5:0]  pulse;
   wire logic [15:0] lvl;
   wire logic [33:0] dpo;
   logic [31:0] dtab[9] = '{32'h8000_0000, 32'h4000_0000, 32'h2000_0000, 32'h1000_0000, 32'h0400_0000,
                            32'h0200_0000, 32'h0100_0000, 32'hFFFF_FFFF, 32'h1000_0000};

   rlcc_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(aw_rdy),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(w_rdy),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(ar_rdy), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .core_soft_reset(pulse[5]), .timing_gen_soft_reset(pulse[4]),
      .reg_block_reset(pulse[3]), .sw_irq_mask(irq_mask), .software_irq_out(pulse[2]),
      .advertising_abort(pulse[1]), .scan_abort(pulse[0]), .rftest_tx_endless(f[0]),
      .rftest_rx_endless(f[1]), .tx_byte_done(f[2]), .tx_crc_done(f[3]), .rx_access_addr_found(f[4]),
      .rx_packet_done(f[5]), .rftest_busy(busy), .rftest_stop(rft_stop), .rf_power_off(pwroff),
      .more_data_disable(lvl[15]), .sequence_number_disable(lvl[14]), .ack_scheme_disable(lvl[13]),
      .cipher_disable(lvl[12]), .whitening_disable(lvl[11]), .crc_strip_disable(lvl[10]),
      .hop_remap_disable(lvl[9]), .adv_error_filter_enable(lvl[8]), .exchange_prefetch_enable(lvl[7]),
      .default_rx_window_us(lvl[6:3]), .sync_word_error_limit(lvl[2:0]), .peer_more_data(r[0]),
      .local_more_data(r[1]), .exchange_continue(dpo[33]), .hw_sn(r[2]), .desc_sn(r[3]), .hw_nesn(r[4]),
      .desc_nesn(r[5]), .rx_hdr_valid(r[6]), .rx_sn_mismatch(r[7]), .rx_nesn_mismatch(r[8]),
      .tx_sn(dpo[32]), .tx_nesn(dpo[31]), .sn_error(dpo[30]), .nesn_error(dpo[29]),
      .link_cipher_enable(r[9]), .payload_encrypt(dpo[28]), .mic_generate(dpo[27]), .tx_data_bit(r[10]),
      .whiten_bit(r[11]), .line_bit(dpo[26]), .tx_crc(r[39:16]), .tx_crc_out(dpo[25:2]),
      .rx_pkt_valid(r[12]), .rx_pkt_error(r[13]), .rx_on_adv_channel(r[14]), .rx_report(dpo[1]),
      .sync_candidate(r[15]), .sync_bit_errors(r[45:40]), .sync_found(dpo[0]));

   initial begin
      aclk = 1'h0;
      forever #25 aclk = ~aclk;
   end

   // Pulses are one cycle wide, so they are counted rather than polled
   always @(posedge aclk) begin
      stops <= stops + rft_stop;
      pwr <= pwr + pwroff;
   end

   task automatic compare(input logic [63:0] got, exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      bready <= 1'h1;
      // Each channel is released on its own handshake; the slave may take them apart
      fork
         begin do @(posedge aclk); while (!aw_rdy); awvalid <= 1'h0; end
         begin do @(posedge aclk); while (!w_rdy); wvalid <= 1'h0; end
      join
      do @(posedge aclk);
      while (!bvalid);
      resp = bresp;
      pl = pulse;
   endtask

   task automatic rd(input logic [31:0] a);
      arvalid <= 1'h1;
      araddr <= a;
      rready <= 1'h1;
      do @(posedge aclk);
      while (!ar_rdy);
      arvalid <= 1'h0;
      do @(posedge aclk);
      while (!rvalid);
      rdat = rdata;
      resp = rresp;
   endtask

   function automatic logic [33:0] dexp(input logic [31:0] c, input logic [45:0] x);
      return {~c[22] & (x[0] | x[1]), c[21] ? x[3] : x[2], c[20] ? x[5] : x[4], x[6] & x[7] & ~c[21],
              x[6] & x[8] & ~c[20], x[9] & ~c[19], x[9], x[10] ^ (x[11] & ~c[18]), c[17] ? 24'h0 : x[39:16],
              x[12] & ~(c[9] & x[14] & x[13]), x[15] & (x[45:40] <= {3'h0, c[2:0]})};
   endfunction

   task automatic step(input logic [31:0] d, input logic [3:0] s);
      logic [31:0] lm;
      lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      // Software never programs a zero receive window
      if (d[7:4] == 4'h0) begin
         d[7:4] = 4'hA;
      end
      wr(`RLCC_CTRL_OFS, d, s);
      compare(resp, `RLCC_RESP_OKAY);
      compare(pl, {6{s[3]}} & {d[31:29], d[28] & irq_mask, d[25:24]});
      // After a register reset software acknowledges interrupt status, which lives outside this block
      if (d[29] && s[3]) begin
         wr(`RLCC_CTRL_OFS + 32'h18, 32'hFFFF_FFFF, 4'hF);
         compare({resp, pl}, {`RLCC_RESP_SLVERR, 6'h0});
      end
      m = (d[29] & s[3]) ? 32'h0 : (m & ~(lm & `RLCC_ST_MASK)) | (d & lm & `RLCC_ST_MASK);
      rd(`RLCC_CTRL_OFS);
      compare(rdat, m);
      compare(lvl, {m[22:16], m[9:8], m[7:4], m[2:0]});
      repeat (3) begin
         r <= {6'($urandom_range(0, 9)), 8'($urandom), $urandom};
         @(posedge aclk);
         @(posedge aclk);
         compare(dpo, dexp(m, r));
      end
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_mask} = 7'h0;
      {awaddr, wdata, araddr, wstrb, r, f, m} = 184'h0;
      void'($urandom(47));
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`RLCC_CTRL_OFS);
      compare({resp, rdat}, {`RLCC_RESP_OKAY, `RLCC_CTRL_RST});
      rd(`RLCC_CTRL_OFS + 32'h8);
      compare({resp, rdat}, {`RLCC_RESP_SLVERR, 32'h0});
      wr(`RLCC_CTRL_OFS + 32'h8, 32'hFFFF_FFFF, 4'hF);
      compare({resp, pl}, {`RLCC_RESP_SLVERR, 6'h0});
      // Fixed action-bit table first, then random words and strobes
      for (int i = 0; i < 24; i++) begin
         irq_mask <= (i < 8) ? 1'h1 : (i == 8) ? 1'h0 : 1'($urandom);
         step((i < 9) ? dtab[i] : $urandom, (i < 9) ? 4'hF : 4'($urandom));
      end
      f <= 6'h01;
      wr(`RLCC_CTRL_OFS, 32'h0400_0000, 4'h8);
      repeat (4) @(posedge aclk);
      compare({busy, 8'(stops), 8'(pwr)}, {1'h1, 8'h0, 8'h0});
      f <= 6'h0D;
      repeat (6) @(posedge aclk);
      compare({busy, 8'(stops), 8'(pwr)}, {1'h0, 8'h1, 8'h0});
      f <= 6'h02;
      wr(`RLCC_CTRL_OFS, 32'h0400_0000, 4'h8);
      repeat (6) @(posedge aclk);
      compare({busy, 8'(stops), 8'(pwr)}, {1'h0, 8'h2, 8'h1});
      f <= 6'h12;
      wr(`RLCC_CTRL_OFS, 32'h0400_0000, 4'h8);
      repeat (4) @(posedge aclk);
      compare({busy, 8'(stops), 8'(pwr)}, {1'h1, 8'h2, 8'h1});
      f <= 6'h32;
      repeat (6) @(posedge aclk);
      compare({busy, 8'(stops), 8'(pwr)}, {1'h0, 8'h3, 8'h1});
      test_done;
   end

   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      test_done;
   end
endmodule
`default_nettype wire
